//--- trh_gate.sv
// Purpose: Health tests and output gating for a physical random source
// Assumes: Raw bits arrive synchronous to SYS_CLK with a valid strobe
// Notes: Any failure is permanent until reset; output never resumes
`timescale 1ns/100ps
module trh_gate #(
	parameter int STARTUP_N = trh_pkg::STARTUP_BITS,
	parameter int RUN_N = trh_pkg::RUN_LIMIT
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RESETN,
	// Raw entropy stream
	input wire logic RAW_VALID,
	input wire logic RAW_BIT,
	// Consumer controls
	input wire logic WIDE_MODE,
	input wire logic SELFTEST_REQ,
	// Random output
	output logic [15:0] RND_WORD,
	output logic RND_VALID,
	// Status
	output logic READY,
	output logic ALARM,
	output logic ALARM_LINE
);
	localparam int SW = $clog2(STARTUP_N + 1);
	localparam int RW = $clog2(RUN_N + 1);

	trh_pkg::trh_state_type state_r, state_nxt;
	logic [SW-1:0] boot_cnt_r, boot_cnt_nxt;
	logic [RW-1:0] run_cnt_r, run_cnt_nxt;
	logic last_bit_r, last_bit_nxt;
	logic [15:0] shift_r, shift_nxt;
	logic [4:0] fill_r, fill_nxt;
	logic [15:0] prev_word_r, prev_word_nxt;
	logic have_prev_r, have_prev_nxt;
	logic [15:0] word_r, word_nxt;
	logic valid_r, valid_nxt;
	logic alarm_r, alarm_nxt;
	logic ready_r, ready_nxt;
	logic [2:0] st_cnt_r, st_cnt_nxt;
	logic line_r, line_nxt;
	logic win_done, win_fail;
	logic total_fail, word_full, repeat_fail;
	logic [15:0] new_word;

	// ------------------------------------------------------------
	// Online statistical test
	// ------------------------------------------------------------
	// Runs on every raw bit, in every phase, so a window bounds detection
	trh_window_test #(
		.WIN(trh_pkg::WIN_BITS),
		.LO(trh_pkg::ONES_LO),
		.HI(trh_pkg::ONES_HI)
	) u_win (
		.clk(SYS_CLK),
		.resetn(RESETN),
		.bit_valid(RAW_VALID),
		.bit_in(RAW_BIT),
		.win_done(win_done),
		.win_fail(win_fail)
	);

	// ------------------------------------------------------------
	// Total failure, assembly and gating
	// ------------------------------------------------------------
	// Stuck source shows as a long run of identical raw bits
	always_comb begin
		run_cnt_nxt = run_cnt_r;
		last_bit_nxt = last_bit_r;
		total_fail = 1'b0;
		if (RAW_VALID) begin
			last_bit_nxt = RAW_BIT;
			if (RAW_BIT == last_bit_r) begin
				// Count holds repeats after the first bit, so RUN_N bits end at RUN_N-2
				if (run_cnt_r == RW'(RUN_N - 2)) begin
					total_fail = 1'b1;
					run_cnt_nxt = run_cnt_r;
				end else begin
					run_cnt_nxt = run_cnt_r + 1'b1;
				end
			end else begin
				run_cnt_nxt = '0;
			end
		end
	end

	// Word packing; width chosen by WIDE_MODE, narrow words sit low
	always_comb begin
		shift_nxt = shift_r;
		fill_nxt = fill_r;
		word_full = 1'b0;
		if (RAW_VALID) begin
			shift_nxt = {shift_r[14:0], RAW_BIT};
			if (fill_r == (WIDE_MODE ? 5'h0f : 5'h07)) begin
				word_full = 1'b1;
				fill_nxt = 5'h00;
			end else begin
				fill_nxt = fill_r + 5'h01;
			end
		end
		new_word = WIDE_MODE ? shift_nxt : {8'h00, shift_nxt[7:0]};
	end

	// Continuous test: a word equal to the previous one is a failure
	assign repeat_fail = word_full && have_prev_r && (new_word == prev_word_r);

	// Phase control and output gating
	always_comb begin
		state_nxt = state_r;
		boot_cnt_nxt = boot_cnt_r;
		prev_word_nxt = prev_word_r;
		have_prev_nxt = have_prev_r;
		word_nxt = word_r;
		valid_nxt = 1'b0;
		alarm_nxt = alarm_r;
		unique case (state_r)
			trh_pkg::TRH_STARTUP: begin
				// Nothing leaves until enough bits and a passing window
				if (RAW_VALID && boot_cnt_r != SW'(STARTUP_N)) begin
					boot_cnt_nxt = boot_cnt_r + 1'b1;
				end
				if (boot_cnt_r == SW'(STARTUP_N) && win_done && !win_fail) begin
					state_nxt = trh_pkg::TRH_RUN;
				end
			end
			trh_pkg::TRH_RUN: begin
				if (word_full) begin
					prev_word_nxt = new_word;
					have_prev_nxt = 1'b1;
					word_nxt = new_word;
					valid_nxt = 1'b1;
				end
			end
			trh_pkg::TRH_FAILED: begin
			end
		endcase
		// Failure in the same cycle as word completion drops that word
		if (total_fail || (win_done && win_fail) || repeat_fail) begin
			state_nxt = trh_pkg::TRH_FAILED;
			valid_nxt = 1'b0;
			alarm_nxt = 1'b1;
		end
		if (state_r == trh_pkg::TRH_FAILED) begin
			valid_nxt = 1'b0;
		end
		// Ready is registered so the pin comes straight from a flop
		ready_nxt = (state_nxt == trh_pkg::TRH_RUN);
	end

	// Self-test drives the alarm line for a fixed time on request
	always_comb begin
		st_cnt_nxt = st_cnt_r;
		if (SELFTEST_REQ && st_cnt_r == 3'h0) begin
			st_cnt_nxt = 3'(trh_pkg::SELFTEST_CYC);
		end else if (st_cnt_r != 3'h0) begin
			st_cnt_nxt = st_cnt_r - 3'h1;
		end
		line_nxt = alarm_nxt || (st_cnt_nxt != 3'h0);
	end

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_r <= trh_pkg::TRH_STARTUP;
			boot_cnt_r <= '0;
			run_cnt_r <= '0;
			last_bit_r <= 1'b0;
			shift_r <= 16'h0000;
			fill_r <= 5'h00;
			prev_word_r <= 16'h0000;
			have_prev_r <= 1'b0;
			word_r <= 16'h0000;
			valid_r <= 1'b0;
			alarm_r <= 1'b0;
			ready_r <= 1'b0;
			st_cnt_r <= 3'h0;
			line_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			boot_cnt_r <= boot_cnt_nxt;
			run_cnt_r <= run_cnt_nxt;
			last_bit_r <= last_bit_nxt;
			shift_r <= shift_nxt;
			fill_r <= fill_nxt;
			prev_word_r <= prev_word_nxt;
			have_prev_r <= have_prev_nxt;
			word_r <= word_nxt;
			valid_r <= valid_nxt;
			alarm_r <= alarm_nxt;
			ready_r <= ready_nxt;
			st_cnt_r <= st_cnt_nxt;
			line_r <= line_nxt;
		end
	end

	assign RND_WORD = word_r;
	assign RND_VALID = valid_r;
	assign READY = ready_r;
	assign ALARM = alarm_r;
	assign ALARM_LINE = line_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_no_out_failed: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		$past(state_r) == trh_pkg::TRH_FAILED |-> !RND_VALID)
		else $error("Output word after failure");
	a_fail_drops: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		total_fail |=> !RND_VALID ##1 !RND_VALID)
		else $error("Word escaped after total failure");
	a_win_fail_alarm: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		win_done && win_fail |=> ALARM && state_r == trh_pkg::TRH_FAILED)
		else $error("Online defect not flagged");
	a_boot_gate: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		state_r == trh_pkg::TRH_STARTUP |=> !RND_VALID)
		else $error("Output before start-up test");
	a_width_narrow: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		RND_VALID && !$past(WIDE_MODE) |-> RND_WORD[15:8] == 8'h00)
		else $error("Narrow word has high bits");
	a_repeat_stop: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		repeat_fail |=> !RND_VALID && ALARM)
		else $error("Repeated word not caught");
	a_selftest_line: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		SELFTEST_REQ && st_cnt_r == 3'h0 |=> ALARM_LINE [*4])
		else $error("Self-test did not drive alarm line");
	a_valid_ready: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		RND_VALID |-> $past(state_r) == trh_pkg::TRH_RUN)
		else $error("Valid while output withheld");
	a_alarm_sticky: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		ALARM |=> ALARM)
		else $error("Alarm flag cleared without reset");

endmodule // trh_gate

//--- trh_pkg.sv
// Purpose: Shared constants for the health-gated random output block
// Assumes: One 25 MHz system clock, active-low asynchronous reset
// Notes: Test thresholds are plain defaults, tune per entropy source
package trh_pkg;

	// ------------------------------------------------------------
	// Timing and test sizes
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int STARTUP_BITS = 1024;           // Raw bits seen before first release
	localparam int RUN_LIMIT = 32;                // Identical raw bits meaning total failure
	localparam int WIN_BITS = 256;                // Online test window length
	localparam int ONES_LO = 96;                  // Least tolerable count of ones per window
	localparam int ONES_HI = 160;                 // Largest tolerable count of ones per window
	localparam int SELFTEST_CYC = 4;              // Cycles the forced alarm is held

	// Operating phases
	typedef enum logic [1:0] {
		TRH_STARTUP,
		TRH_RUN,
		TRH_FAILED
	} trh_state_type;

endpackage

//--- trh_window_test.sv
// Purpose: Windowed ones-count statistical test on the raw bit stream
// Assumes: One raw bit per cycle when bit_valid is high
// Notes: Reports one pass or fail pulse at each window end
`timescale 1ns/100ps
module trh_window_test #(
	parameter int WIN = trh_pkg::WIN_BITS,
	parameter int LO = trh_pkg::ONES_LO,
	parameter int HI = trh_pkg::ONES_HI
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Raw stream
	input wire logic bit_valid,
	input wire logic bit_in,
	// Verdict
	output logic win_done,
	output logic win_fail
);
	localparam int CW = $clog2(WIN + 1);

	logic [CW-1:0] cnt_r, cnt_nxt;
	logic [CW-1:0] ones_r, ones_nxt;
	logic done_r, done_nxt;
	logic fail_r, fail_nxt;
	logic [CW-1:0] ones_sum;

	// Count bits and ones, judge at the window end
	always_comb begin
		ones_sum = ones_r + CW'(bit_in);
		cnt_nxt = cnt_r;
		ones_nxt = ones_r;
		done_nxt = 1'b0;
		fail_nxt = 1'b0;
		if (bit_valid) begin
			if (cnt_r == CW'(WIN - 1)) begin
				done_nxt = 1'b1;
				fail_nxt = (ones_sum < CW'(LO)) || (ones_sum > CW'(HI));
				cnt_nxt = '0;
				ones_nxt = '0;
			end else begin
				cnt_nxt = cnt_r + 1'b1;
				ones_nxt = ones_sum;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= '0;
			ones_r <= '0;
			done_r <= 1'b0;
			fail_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			ones_r <= ones_nxt;
			done_r <= done_nxt;
			fail_r <= fail_nxt;
		end
	end

	assign win_done = done_r;
	assign win_fail = fail_r;

endmodule // trh_window_test

//--- trh_cpu_model.sv
// Purpose: Consumer core model taking random words
// Assumes: A word is read in its one valid cycle
// Notes: Self-test request is one cycle per software command
`timescale 1ns/100ps
module trh_cpu_model (
	// Clock
	input wire logic clk,
	// From the block
	input wire logic [15:0] rnd_word,
	input wire logic rnd_valid,
	// Software side
	input wire logic st_cmd,
	output logic selftest_req,
	output logic got,
	output logic [15:0] got_word
);
	// Valid lasts one cycle, so take the word on the pulse
	always_ff @(posedge clk) begin
		got <= rnd_valid;
		if (rnd_valid)
			got_word <= rnd_word;
		selftest_req <= st_cmd;
	end
endmodule // trh_cpu_model

//--- trh_gate_bench.sv
// Purpose: Self-checking bench for the health-gated random output
// Assumes: Small start-up and run limits keep the run short
// Notes: Bits go in inverse pairs so healthy streams pass every test
`timescale 1ns/100ps
module trh_gate_bench;
	logic sys_clk, resetn, raw_valid, raw_bit, wide_mode, st_cmd;
	logic rnd_valid, ready, alarm, alarm_line, selftest_req, got;
	logic [15:0] rnd_word, got_word, last_w;
	logic [31:0] seed = 32'h53;
	logic [15:0] exp_q[$];
	int fail_count = 0;
	int n_checks = 0;

	trh_gate #(.STARTUP_N(64), .RUN_N(8)) u_trh_gate (.SYS_CLK(sys_clk), .RESETN(resetn),
		.RAW_VALID(raw_valid), .RAW_BIT(raw_bit), .WIDE_MODE(wide_mode),
		.SELFTEST_REQ(selftest_req), .RND_WORD(rnd_word), .RND_VALID(rnd_valid),
		.READY(ready), .ALARM(alarm), .ALARM_LINE(alarm_line));
	trh_cpu_model u_trh_cpu_model (.clk(sys_clk), .rnd_word(rnd_word),
		.rnd_valid(rnd_valid), .st_cmd(st_cmd), .selftest_req(selftest_req),
		.got(got), .got_word(got_word));

	// 25 MHz clock
	initial begin
		sys_clk = 1'h0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
		n_checks++;
		if (seen !== want) begin
			fail_count++;
			$display("MISMATCH %0t %s", $time, what);
		end
	endtask

	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction

	// Each bit followed by its inverse: exact balance, runs of two at most
	function automatic logic [15:0] pairs(input logic [7:0] r);
		logic [15:0] p;
		for (int i = 0; i < 8; i++)
			p[2*i+:2] = {r[i], ~r[i]};
		return p;
	endfunction

	// Raw bits MSB first, one per cycle, back to back
	task automatic send(input logic [15:0] w, input int n, input bit keep);
		if (keep)
			exp_q.push_back(w);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge sys_clk);
			raw_valid <= 1'h1;
			raw_bit <= w[i];
		end
	endtask

	task automatic idle(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			raw_valid <= 1'h0;
		end
		#1;
	endtask

	// Healthy word, never equal to the last one delivered
	task automatic good(input int n, input bit keep);
		logic [15:0] w;
		w = pairs(8'(rnd()));
		if (n == 8)
			w = {8'h00, w[7:0]};
		if (w == last_w)
			w = w ^ 16'h0003;
		if (keep)
			last_w = w;
		send(w, n, keep);
	endtask

	task automatic do_reset();
		@(posedge sys_clk);
		resetn <= 1'h0;
		raw_valid <= 1'h0;
		wide_mode <= 1'h0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'h1;
		last_w = 16'h0000;
	endtask

	task automatic boot();
		repeat (16) good(8, 1'h0);
		idle(1);
		check(ready, 1'h0, "early ready");
		repeat (16) good(8, 1'h0);
		idle(4);
		check(ready, 1'h1, "not ready");
	endtask

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Take the oldest note whenever the consumer got a word
	always @(posedge sys_clk) begin
		if (got === 1'h1) begin
			if (exp_q.size() == 0)
				check(16'h0001, 16'h0000, "word while withheld");
			else
				check(got_word, exp_q.pop_front(), "word");
		end
	end

	// Whole run is about a thousand cycles
	initial begin
		repeat (8000) @(posedge sys_clk);
		fail_count++;
		final_report();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		resetn = 1'h0;
		raw_valid = 1'h0;
		raw_bit = 1'h0;
		wide_mode = 1'h0;
		st_cmd = 1'h0;
		last_w = 16'h0000;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'h1;
		boot();
		repeat (4) good(8, 1'h1);
		idle(1);
		@(posedge sys_clk);
		wide_mode <= 1'h1;
		repeat (4) good(16, 1'h1);
		idle(4);
		// Alarm line self-test
		@(posedge sys_clk);
		st_cmd <= 1'h1;
		@(posedge sys_clk);
		st_cmd <= 1'h0;
		repeat (4) begin
			@(posedge sys_clk);
			#1;
			check(alarm_line, 1'h1, "self-test line low");
		end
		idle(1);
		check(alarm_line, 1'h0, "self-test too long");
		check(alarm, 1'h0, "alarm on self-test");
		// Repeated word trips the generator test, then nothing leaves
		good(16, 1'h1);
		send(last_w, 16, 1'h0);
		idle(4);
		check(alarm, 1'h1, "repeat not flagged");
		check(ready, 1'h0, "ready after fault");
		repeat (4) good(16, 1'h0);
		idle(4);
		check(alarm, 1'h1, "alarm not sticky");
		// Stuck source in run phase
		do_reset();
		idle(1);
		check(alarm, 1'h0, "alarm kept by reset");
		boot();
		good(8, 1'h1);
		good(8, 1'h1);
		send(16'h0000, 16, 1'h0);
		idle(4);
		check(alarm, 1'h1, "stuck not flagged");
		// Biased window during start-up
		do_reset();
		repeat (31) send(16'h0077, 8, 1'h0);
		idle(2);
		check(alarm, 1'h0, "early window verdict");
		send(16'h0077, 8, 1'h0);
		idle(4);
		check(alarm, 1'h1, "bias not flagged");
		check(ready, 1'h0, "ready on bias");
		check(16'(exp_q.size()), 16'h0000, "words missing");
		final_report();
	end
endmodule // trh_gate_bench
